// File: dda_map.vh
// constants and bus map of the dual converter input logic
//
// Overview of operation
// - serial: clear low zeros shift and both converter registers immediately.
// - serial: selected clock edge shifts data into bit 23, rest moves downward.
// - serial: first transfer loads bits 23..12, bit 12 most significant.
// - serial: second transfer loads bits 11..0, bit 0 most significant.
// - serial: both transfers together load both converters at once.
// - 8+4: store with half bit low writes low byte from bits 7..0.
// - 8+4: half bit high writes high nibble from bits 3..0, bit 3 MSB.
// - 8+4: channel bit high steers the write to the second converter.
// - 8+4: transfer low, select high, store low updates both converters.
// - 8+4: transfer, select and store all low make converters transparent.
// - 12-bit: with store low, rising select edge loads bus into that converter.
// - 12-bit: store rising with one select low loads only that converter.
// - 12-bit: store rising with both selects low loads both converters.
`ifndef DDA_MAP_VH
`define DDA_MAP_VH

`define DDA_VARIANT_SERIAL 2'h0
`define DDA_VARIANT_BYTE 2'h1
`define DDA_VARIANT_WORD 2'h2

`define DDA_WORD_W 12
`define DDA_LOW_W 8
`define DDA_HIGH_W 4

`define DDA_OFS_CTRL 8'h00
`define DDA_OFS_FIRST 8'h04
`define DDA_OFS_SECOND 8'h08
`define DDA_OFS_SHIFT 8'h0c
`define DDA_OFS_COUNT 8'h10
`define DDA_OFS_INFO 8'h14
`define DDA_OFS_INPUT 8'h18
`define DDA_OFS_PINS 8'h1c

`define DDA_CTRL_HOLD_BIT 0
`define DDA_CTRL_RESET 1'h0
`define DDA_COUNT_W 16

`endif

// File: dda_sync.v
// two-stage synchroniser for a group of pin inputs
`default_nettype none
module dda_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire srst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    // meta feeds only the second stage
    always @(posedge clk) begin
        if (srst) begin
            meta <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // dda_sync
`default_nettype wire

// File: dda_clear_sync.v
// clear pin conditioner: asserts at once, releases on the clock
`default_nettype none
module dda_clear_sync (
    input wire clk,
    input wire clear_n,
    output reg release_n
);
    reg stage;

    // release is synchronised so no flop leaves clear on a racing edge
    always @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            stage <= 1'b0;
            release_n <= 1'b0;
        end else begin
            stage <= 1'b1;
            release_n <= stage;
        end
    end
endmodule // dda_clear_sync
`default_nettype wire

// File: dda_top.v
// dual converter digital input logic with wishbone readback
//
// The implementer's own choices: the Wishbone slave port and the address map.
`include "dda_map.vh"
`default_nettype none
module dda_top #(
    parameter [1:0] VARIANT = `DDA_VARIANT_SERIAL,
    parameter WORD_W = `DDA_WORD_W,
    parameter LOW_W = `DDA_LOW_W,
    parameter COUNT_W = `DDA_COUNT_W
) (
    input wire clk,
    input wire srst,
    input wire clear_n,
    input wire link_clk,
    input wire serial_input,
    input wire select_n,
    input wire transfer_first_n,
    input wire transfer_second_n,
    input wire transfer_both_n,
    input wire store_strobe_n,
    input wire channel_select_bit,
    input wire half_select_bit,
    input wire select_first_n,
    input wire select_second_n,
    input wire [WORD_W-1:0] parallel_data,
    output reg [WORD_W-1:0] first_word,
    output reg [WORD_W-1:0] second_word,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o
);
    localparam SHIFT_W = 2 * WORD_W;
    localparam HIGH_W = WORD_W - LOW_W;

    reg [SHIFT_W-1:0] shift_reg;
    reg hold_clear;
    reg [COUNT_W-1:0] count_first;
    reg [COUNT_W-1:0] count_second;
    reg first_lvl_d;
    reg second_lvl_d;
    wire first_lvl;
    wire second_lvl;
    wire [WORD_W-1:0] input_first;
    wire [WORD_W-1:0] input_second;
    wire [15:0] pin_view;
    wire clr_rel_n;
    wire wb_req;
    wire wb_write;
    wire first_pulse;
    wire second_pulse;
    reg [31:0] next_rdata;

    // bit order of a converter word is reversed against the shift chain
    function [WORD_W-1:0] reverse_word;
        input [WORD_W-1:0] v;
        integer i;
        begin
            for (i = 0; i < WORD_W; i = i + 1) begin
                reverse_word[WORD_W-1-i] = v[i];
            end
        end
    endfunction

    function [COUNT_W-1:0] bump;
        input [COUNT_W-1:0] c;
        begin
            bump = c + {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    dda_clear_sync u_clear (
        .clk(clk),
        .clear_n(clear_n),
        .release_n(clr_rel_n)
    );

    generate
        if (VARIANT == `DDA_VARIANT_SERIAL) begin : g_serial
            wire [4:0] s;
            reg lclk_d;
            wire lclk_s;
            wire sin_s;
            wire sel_s;
            wire upa_s;
            wire upb_s;

            // data and clock share the synchroniser depth, so they stay aligned
            dda_sync #(.WIDTH(5)) u_sync (
                .clk(clk),
                .srst(srst),
                .async_in({link_clk, serial_input, select_n,
                           transfer_first_n, transfer_second_n}),
                .sync_out(s)
            );
            assign lclk_s = s[4];
            assign sin_s = s[3];
            assign sel_s = s[2];
            assign upa_s = s[1];
            assign upb_s = s[0];

            always @(posedge clk or negedge clr_rel_n) begin
                if (!clr_rel_n) begin
                    shift_reg <= {SHIFT_W{1'b0}};
                    first_word <= {WORD_W{1'b0}};
                    second_word <= {WORD_W{1'b0}};
                    // starts high like the synchroniser: no false edge
                    lclk_d <= 1'b1;
                end else if (srst || hold_clear) begin
                    shift_reg <= {SHIFT_W{1'b0}};
                    first_word <= {WORD_W{1'b0}};
                    second_word <= {WORD_W{1'b0}};
                    lclk_d <= 1'b1;
                end else begin
                    lclk_d <= lclk_s;
                    // rising link clock edge is the active edge
                    if (!sel_s && lclk_s && !lclk_d) begin
                        shift_reg <= {sin_s, shift_reg[SHIFT_W-1:1]};
                    end
                    // transfers are level driven; both low loads both
                    if (!upa_s) begin
                        first_word <= reverse_word(
                            shift_reg[SHIFT_W-1:WORD_W]);
                    end
                    if (!upb_s) begin
                        second_word <= reverse_word(
                            shift_reg[WORD_W-1:0]);
                    end
                end
            end

            assign first_lvl = !upa_s;
            assign second_lvl = !upb_s;
            assign input_first = reverse_word(shift_reg[SHIFT_W-1:WORD_W]);
            assign input_second = reverse_word(shift_reg[WORD_W-1:0]);
            assign pin_view = {11'h000, lclk_s, sin_s, sel_s, upa_s, upb_s};
        end else if (VARIANT == `DDA_VARIANT_BYTE) begin : g_byte
            wire [LOW_W+4:0] s;
            wire [LOW_W-1:0] bus_s;
            wire ch_s;
            wire half_s;
            wire sel_s;
            wire st_s;
            wire tb_s;
            wire write_on;
            wire update_on;
            wire transparent_on;
            reg [LOW_W-1:0] low_byte_first;
            reg [LOW_W-1:0] low_byte_second;
            reg [HIGH_W-1:0] high_nibble_first;
            reg [HIGH_W-1:0] high_nibble_second;
            reg [LOW_W-1:0] next_low_byte_first;
            reg [LOW_W-1:0] next_low_byte_second;
            reg [HIGH_W-1:0] next_high_nibble_first;
            reg [HIGH_W-1:0] next_high_nibble_second;

            dda_sync #(.WIDTH(LOW_W + 5)) u_sync (
                .clk(clk),
                .srst(srst),
                .async_in({parallel_data[LOW_W-1:0], channel_select_bit,
                           half_select_bit, select_n, store_strobe_n,
                           transfer_both_n}),
                .sync_out(s)
            );
            assign bus_s = s[LOW_W+4:5];
            assign ch_s = s[4];
            assign half_s = s[3];
            assign sel_s = s[2];
            assign st_s = s[1];
            assign tb_s = s[0];

            // input registers are level loaded while select and store are low
            assign write_on = !sel_s && !st_s;
            assign update_on = !tb_s && sel_s && !st_s;
            assign transparent_on = !tb_s && !sel_s && !st_s;

            always @* begin
                next_low_byte_first = low_byte_first;
                next_low_byte_second = low_byte_second;
                next_high_nibble_first = high_nibble_first;
                next_high_nibble_second = high_nibble_second;
                if (write_on) begin
                    if (!ch_s && !half_s) begin
                        next_low_byte_first = bus_s;
                    end else if (!ch_s && half_s) begin
                        next_high_nibble_first = bus_s[HIGH_W-1:0];
                    end else if (ch_s && !half_s) begin
                        next_low_byte_second = bus_s;
                    end else begin
                        next_high_nibble_second = bus_s[HIGH_W-1:0];
                    end
                end
            end

            always @(posedge clk or negedge clr_rel_n) begin
                if (!clr_rel_n) begin
                    low_byte_first <= {LOW_W{1'b0}};
                    low_byte_second <= {LOW_W{1'b0}};
                    high_nibble_first <= {HIGH_W{1'b0}};
                    high_nibble_second <= {HIGH_W{1'b0}};
                    first_word <= {WORD_W{1'b0}};
                    second_word <= {WORD_W{1'b0}};
                end else if (srst || hold_clear) begin
                    low_byte_first <= {LOW_W{1'b0}};
                    low_byte_second <= {LOW_W{1'b0}};
                    high_nibble_first <= {HIGH_W{1'b0}};
                    high_nibble_second <= {HIGH_W{1'b0}};
                    first_word <= {WORD_W{1'b0}};
                    second_word <= {WORD_W{1'b0}};
                end else begin
                    low_byte_first <= next_low_byte_first;
                    low_byte_second <= next_low_byte_second;
                    high_nibble_first <= next_high_nibble_first;
                    high_nibble_second <= next_high_nibble_second;
                    // transparent mode takes the word being written this cycle
                    if (update_on || transparent_on) begin
                        first_word <= {next_high_nibble_first,
                                       next_low_byte_first};
                        second_word <= {next_high_nibble_second,
                                        next_low_byte_second};
                    end
                end
            end

            always @(posedge clk) begin
                shift_reg <= {SHIFT_W{1'b0}};
            end

            assign first_lvl = update_on || transparent_on;
            assign second_lvl = update_on || transparent_on;
            assign input_first = {high_nibble_first, low_byte_first};
            assign input_second = {high_nibble_second, low_byte_second};
            assign pin_view = {3'h0, bus_s, ch_s, half_s, sel_s, st_s, tb_s};
        end else begin : g_word
            wire [WORD_W+2:0] s;
            wire [WORD_W-1:0] bus_s;
            wire csa_s;
            wire csb_s;
            wire st_s;
            reg csa_d;
            reg csb_d;
            reg st_d;
            wire a_rise;
            wire b_rise;
            wire st_rise;
            wire load_a;
            wire load_b;

            // bus and strobes share the synchroniser depth, so they stay aligned
            dda_sync #(.WIDTH(WORD_W + 3)) u_sync (
                .clk(clk),
                .srst(srst),
                .async_in({parallel_data, select_first_n, select_second_n,
                           store_strobe_n}),
                .sync_out(s)
            );
            assign bus_s = s[WORD_W+2:3];
            assign csa_s = s[2];
            assign csb_s = s[1];
            assign st_s = s[0];

            assign a_rise = csa_s && !csa_d;
            assign b_rise = csb_s && !csb_d;
            assign st_rise = st_s && !st_d;
            assign load_a = (a_rise && !st_s) || (st_rise && !csa_s);
            assign load_b = (b_rise && !st_s) || (st_rise && !csb_s);

            // no clear pin in this variant; srst and software clear only
            always @(posedge clk) begin
                if (srst || hold_clear) begin
                    csa_d <= 1'b1;
                    csb_d <= 1'b1;
                    st_d <= 1'b1;
                    first_word <= {WORD_W{1'b0}};
                    second_word <= {WORD_W{1'b0}};
                end else begin
                    csa_d <= csa_s;
                    csb_d <= csb_s;
                    st_d <= st_s;
                    // both selects low at a store edge loads the same word twice
                    if (load_a) begin
                        first_word <= bus_s;
                    end
                    if (load_b) begin
                        second_word <= bus_s;
                    end
                end
            end

            always @(posedge clk) begin
                shift_reg <= {SHIFT_W{1'b0}};
            end

            assign first_lvl = load_a;
            assign second_lvl = load_b;
            assign input_first = bus_s;
            assign input_second = bus_s;
            assign pin_view = {1'b0, bus_s, csa_s, csb_s, st_s};
        end
    endgenerate

    // load counters see the start of each load; the pulse beats a clear
    assign first_pulse = first_lvl && !first_lvl_d;
    assign second_pulse = second_lvl && !second_lvl_d;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_write = wb_req && wb_we_i;

    always @(posedge clk) begin
        if (srst) begin
            first_lvl_d <= 1'b0;
            second_lvl_d <= 1'b0;
            count_first <= {COUNT_W{1'b0}};
            count_second <= {COUNT_W{1'b0}};
        end else begin
            first_lvl_d <= first_lvl;
            second_lvl_d <= second_lvl;
            if (first_pulse) begin
                count_first <= bump(count_first);
            end else if (wb_write && wb_adr_i == `DDA_OFS_COUNT &&
                         wb_sel_i[0]) begin
                count_first <= {COUNT_W{1'b0}};
            end
            if (second_pulse) begin
                count_second <= bump(count_second);
            end else if (wb_write && wb_adr_i == `DDA_OFS_COUNT &&
                         wb_sel_i[2]) begin
                count_second <= {COUNT_W{1'b0}};
            end
        end
    end

    // read mux; unmapped offsets read zero and still acknowledge
    always @* begin
        next_rdata = 32'h00000000;
        if (wb_adr_i == `DDA_OFS_CTRL) begin
            next_rdata[`DDA_CTRL_HOLD_BIT] = hold_clear;
        end else if (wb_adr_i == `DDA_OFS_FIRST) begin
            next_rdata[WORD_W-1:0] = first_word;
        end else if (wb_adr_i == `DDA_OFS_SECOND) begin
            next_rdata[WORD_W-1:0] = second_word;
        end else if (wb_adr_i == `DDA_OFS_SHIFT) begin
            next_rdata[SHIFT_W-1:0] = shift_reg;
        end else if (wb_adr_i == `DDA_OFS_COUNT) begin
            next_rdata[COUNT_W-1:0] = count_first;
            next_rdata[16+COUNT_W-1:16] = count_second;
        end else if (wb_adr_i == `DDA_OFS_INFO) begin
            next_rdata[1:0] = VARIANT;
        end else if (wb_adr_i == `DDA_OFS_INPUT) begin
            next_rdata[WORD_W-1:0] = input_first;
            next_rdata[16+WORD_W-1:16] = input_second;
        end else if (wb_adr_i == `DDA_OFS_PINS) begin
            next_rdata[15:0] = pin_view;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            hold_clear <= `DDA_CTRL_RESET;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
            if (wb_write && wb_adr_i == `DDA_OFS_CTRL && wb_sel_i[0]) begin
                hold_clear <= wb_dat_i[`DDA_CTRL_HOLD_BIT];
            end
        end
    end
endmodule // dda_top
`default_nettype wire

// File: dda_host_model.sv
// host-side serial link driver for the converter input logic
`default_nettype none
module dda_host_model (
    output var logic link_clk,
    output var logic serial_input,
    output var logic select_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 32;
    initial begin
        link_clk = 1'b0;
        serial_input = 1'b1;
        select_n = 1'b1;
    end
    // link clock stands still between frames; active low select optional
    task automatic send(input logic [11:0] first, input logic [11:0] second,
                        input logic active);
        logic [23:0] frame;
        frame = {second, first};
        // 6.5 ns offset keeps the select change off a system clock edge; later 32 ns steps land on some falling edges, never a rising one
        #6.5;
        select_n = !active;
        for (int i = 23; i >= 0; i--) begin
            serial_input = frame[i];
            #HALF link_clk = 1'b1;
            #HALF link_clk = 1'b0;
        end
        #HALF select_n = 1'b1;
        // released line shows the inverse so a stale bit never looks valid
        serial_input = !frame[0];
    endtask
endmodule // dda_host_model
`default_nettype wire

// File: dda_sva.sv
// checker for the dual converter input logic ports
`default_nettype none
module dda_sva #(
    parameter [1:0] VARIANT = 2'h0,
    parameter WORD_W = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clear_n,
    input wire logic select_n,
    input wire logic transfer_first_n,
    input wire logic transfer_second_n,
    input wire logic [WORD_W-1:0] first_word,
    input wire logic [WORD_W-1:0] second_word,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic ser;
    logic [5:0] first_hist;
    logic [5:0] second_hist;
    logic [2:0] quiet_cnt;
    assign ser = (VARIANT == 2'h0);
    // six samples cover the pin synchroniser plus the load flop
    always_ff @(posedge clk) begin
        if (srst) begin
            first_hist <= 6'h0;
            second_hist <= 6'h0;
            quiet_cnt <= 3'h0;
        end else begin
            first_hist <= {first_hist[4:0], !transfer_first_n};
            second_hist <= {second_hist[4:0], !transfer_second_n};
            if (!(select_n && clear_n)) begin
                quiet_cnt <= 3'h0;
            end else if (quiet_cnt != 3'h7) begin
                quiet_cnt <= quiet_cnt + 3'h1;
            end
        end
    end
    AST_CLEAR_ZERO:
        assert property (ser && !clear_n |-> first_word == '0 &&
            second_word == '0) else $error("words not zero under clear");
    AST_CLEAR_RELEASE:
        assert property (ser && $rose(clear_n) |->
            (first_word == '0 && second_word == '0) [*2])
        else $error("words not zero as clear releases");
    AST_FIRST_CAUSE:
        assert property (ser && $changed(first_word) && first_word != '0
            |-> |first_hist) else $error("first word loaded unasked");
    AST_SECOND_CAUSE:
        assert property (ser && $changed(second_word) && second_word != '0
            |-> |second_hist) else $error("second word loaded unasked");
    AST_SHIFT_QUIET:
        assert property (ser && quiet_cnt == 3'h7 && &first_hist &&
            &second_hist |-> $stable(first_word) && $stable(second_word))
        else $error("words moved without selected shifting");
    AST_ACK_NEXT:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_CAUSE:
        assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_UNMAPPED_ZERO:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
            wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // dda_sva
`default_nettype wire

// File: tb_top.sv
// testbench for the dual converter input logic, serial variant
`include "dda_map.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 10000;
    logic clk, srst, clear_n, transfer_first_n, transfer_second_n;
    logic [17:0] spare;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, q;
    logic [3:0] wb_sel_i;
    logic wb_we_i, wb_cyc_i, wb_stb_i;
    wire logic link_clk, serial_input, select_n, wb_ack_o;
    wire logic [11:0] first_word, second_word;
    wire logic [31:0] wb_dat_o;
    int mismatches, check_count, cycles;
    dda_host_model u_host (.link_clk(link_clk), .serial_input(serial_input),
        .select_n(select_n));
    // pins of the parallel variants ride on one spare vector
    dda_top #(.VARIANT(`DDA_VARIANT_SERIAL)) u_dut (.clk(clk), .srst(srst),
        .clear_n(clear_n), .link_clk(link_clk), .serial_input(serial_input),
        .select_n(select_n), .transfer_first_n(transfer_first_n),
        .transfer_second_n(transfer_second_n), .transfer_both_n(spare[12]),
        .store_strobe_n(spare[13]), .channel_select_bit(spare[14]),
        .half_select_bit(spare[15]), .select_first_n(spare[16]),
        .select_second_n(spare[17]), .parallel_data(spare[11:0]),
        .first_word(first_word), .second_word(second_word),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("unexpected at %0t: run too long", $time);
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                got, exp);
        end
    endtask
    function automatic logic [11:0] rev(input logic [11:0] v);
        for (int i = 0; i < 12; i++) rev[i] = v[11-i];
    endfunction
    // one classic cycle; waits for ack however long it takes
    task automatic wb(input logic [7:0] a, input logic we,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1, "bus answer");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        wb(a, 1'b0, 32'h0, 4'hf);
        chk(q, e, what);
    endtask
    task automatic words(input logic [11:0] f, input logic [11:0] s,
                         input string what);
        chk({20'h0, first_word}, {20'h0, f}, what);
        chk({20'h0, second_word}, {20'h0, s}, what);
    endtask
    // both strobes low together when both are asked for
    task automatic pulse(input logic f, input logic s);
        @(posedge clk);
        transfer_first_n <= !f;
        transfer_second_n <= !s;
        repeat (8) @(posedge clk);
        transfer_first_n <= 1'b1;
        transfer_second_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    initial begin
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        srst = 1'b1;
        clear_n = 1'b1;
        transfer_first_n = 1'b1;
        transfer_second_n = 1'b1;
        spare = 18'h3f000;
        wb_adr_i = 8'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(`DDA_OFS_CTRL, 32'h0, "ctrl reset");
        rd(`DDA_OFS_INFO, 32'h0, "variant code");
        rd(8'h40, 32'h0, "unmapped read");
        wb(8'h40, 1'b1, 32'hffffffff, 4'hf);
        words(12'h0, 12'h0, "reset words");
        end_test("reset");
        u_host.send(12'ha5c, 12'h3c1, 1'b1);
        rd(`DDA_OFS_SHIFT, {8'h0, rev(12'ha5c), rev(12'h3c1)}, "shift");
        pulse(1'b1, 1'b0);
        words(12'ha5c, 12'h000, "first only");
        pulse(1'b0, 1'b1);
        words(12'ha5c, 12'h3c1, "second only");
        end_test("single transfers");
        u_host.send(12'h801, 12'hffe, 1'b1);
        pulse(1'b1, 1'b1);
        words(12'h801, 12'hffe, "both at once");
        rd(`DDA_OFS_FIRST, 32'h801, "first readback");
        rd(`DDA_OFS_SECOND, 32'hffe, "second readback");
        rd(`DDA_OFS_INPUT, 32'h0ffe0801, "input view");
        rd(`DDA_OFS_PINS, 32'h7, "idle pins");
        rd(`DDA_OFS_COUNT, 32'h00020002, "load counts");
        wb(`DDA_OFS_COUNT, 1'b1, 32'h0, 4'h5);
        rd(`DDA_OFS_COUNT, 32'h0, "counts cleared");
        end_test("joint transfer");
        spare <= 18'h0a5a5;
        u_host.send(12'h111, 12'h222, 1'b0);
        rd(`DDA_OFS_SHIFT, {8'h0, rev(12'h801), rev(12'hffe)}, "no select");
        words(12'h801, 12'hffe, "foreign pins");
        end_test("deselected");
        wb(`DDA_OFS_CTRL, 1'b1, 32'h1, 4'h1);
        rd(`DDA_OFS_CTRL, 32'h1, "hold readback");
        words(12'h0, 12'h0, "hold words");
        wb(`DDA_OFS_CTRL, 1'b1, 32'h0, 4'h1);
        end_test("hold");
        u_host.send(12'h123, 12'h456, 1'b1);
        pulse(1'b1, 1'b1);
        @(posedge clk);
        clear_n <= 1'b0;
        #1;
        words(12'h0, 12'h0, "clear at once");
        rd(`DDA_OFS_SHIFT, 32'h0, "clear shift");
        clear_n <= 1'b1;
        repeat (6) @(posedge clk);
        words(12'h0, 12'h0, "after clear");
        end_test("clear");
        close_out();
    end
endmodule // tb_top
bind dda_top dda_sva #(.VARIANT(VARIANT), .WORD_W(WORD_W)) u_sva (
    .clk(clk), .srst(srst), .clear_n(clear_n), .select_n(select_n),
    .transfer_first_n(transfer_first_n),
    .transfer_second_n(transfer_second_n),
    .first_word(first_word), .second_word(second_word),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
